/* File: design/ascd_host.sv */
// command host that drives the converter serial link from apb registers
// Summary of operation
// R1: wake command wakes device on eighth clock
// R2: sleep lets running conversion finish first
// R3: only wake ends sleep; wake+sleep gives one
// R4: sleep and wake mirror start pin low/high
// R5: sync clears filter, starts new conversion
// R6: reset command restores registers and filter
// R7: deassert chip select before sending reset
// R8: no traffic for 0.6 ms after reset
// R9: continuous mode result read with 24 clocks
// R10: continuous command sent after data-ready falls
// R11: finish readout before next data-ready fall
// R12: stop command halts automatic result loading
// R13: read-once loads result for 24 clocks
// R14: read-once may ride last result byte
// R15: register read: 2r, 0n, count+1 bytes back
// R16: send no-ops during register readout
// R17: register write: 4r, 0n, count+1 data bytes
// R18: system offset calibration with zero input
// R19: system gain calibration with full-scale input
// R20: self offset calibration shorts inputs
// R21: no traffic for 2^16 device clocks after power-up
// R22: device defaults to continuous read mode
// R23: fixed opcode encodings, F1h never sent
// R24: first byte after select is an opcode
`timescale 1ns/1ps
module ascd_host #(
  parameter int POWERUP_CYC = ascd_pkg::PWRUP_CYC, // power-up hold in pclk cycles
  parameter int RESET_HOLD_CYC = ascd_pkg::RESET_HOLD_CYC // reset hold in pclk cycles
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output ascd_pkg::ascd_link_t link_o, // serial link outputs
  output logic conv_start, // conversion start pin
  input wire logic dout, // device data out
  input wire logic data_ready_n // device data ready, active low
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ascd_pkg::ascd_state_t state; // sequencer state
  ascd_pkg::ascd_cmd_t cmd; // command being run
  logic [31:0] wait_cnt; // long hold counter
  logic [4:0] ph; // half-period counter
  logic [2:0] bitn; // bit within byte
  logic [4:0] bi; // byte index within transfer
  logic [4:0] total; // bytes in this transfer
  logic [7:0] tx; // outgoing byte shifter
  logic [7:0] rx; // incoming byte shifter
  logic [7:0] buffer [0:15]; // register data, both directions
  logic [23:0] result; // last conversion result
  logic cont_mode; // device believed in continuous mode
  logic flag_err; // sticky refused command
  logic flag_done; // sticky transfer finished
  logic dout_m, dout_s; // dout synchroniser
  logic rdy_m, rdy_s, rdy_d; // data-ready synchroniser and history
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_reg_read(input logic [7:0] op);
    return op[7:4] == ascd_pkg::OP_REG_READ_HI;
  endfunction
  function automatic logic is_reg_write(input logic [7:0] op);
    return op[7:4] == ascd_pkg::OP_REG_WRITE_HI;
  endfunction
  function automatic logic is_read_once(input logic [7:0] op);
    return op[7:1] == ascd_pkg::OP_READ_ONCE[7:1];
  endfunction
  function automatic logic is_cont(input logic [7:0] op);
    return op[7:1] == ascd_pkg::OP_CONT_READ[7:1];
  endfunction
  function automatic logic is_stop(input logic [7:0] op);
    return op[7:1] == ascd_pkg::OP_STOP_CONT[7:1];
  endfunction
  function automatic logic is_reset(input logic [7:0] op);
    return op[7:1] == ascd_pkg::OP_RESET[7:1];
  endfunction
  // bytes on the wire for one command
  function automatic logic [4:0] bytes_total(input ascd_pkg::ascd_cmd_t c);
    if (c.res_only) begin
      return ascd_pkg::N_RESULT_BYTES; // R9
    end else if (is_reg_read(c.op) || is_reg_write(c.op)) begin
      return ascd_pkg::N_HDR_BYTES + {1'b0, c.cnt} + 5'h01; // R15 R17
    end else if (is_read_once(c.op)) begin
      return ascd_pkg::N_RESULT_BYTES + 5'h01; // R13
    end
    return 5'h01; // wake, sleep, sync, reset, stop, continuous, calibrations
  endfunction
  // byte sent at position idx of the transfer
  function automatic logic [7:0] tx_byte(input ascd_pkg::ascd_cmd_t c, input logic [4:0] idx);
    logic [4:0] last;
    last = bytes_total(c) - 5'h01;
    if (c.res_only || is_read_once(c.op)) begin
      if (!c.res_only && idx == 5'h00) begin
        return c.op; // R13 R24
      end
      return (c.chain && idx == last) ? ascd_pkg::OP_READ_ONCE : ascd_pkg::OP_NOP; // R14
    end else if (is_reg_read(c.op) || is_reg_write(c.op)) begin
      if (idx == 5'h00) begin
        return c.op; // R15 R17 R24
      end else if (idx == 5'h01) begin
        return {4'h0, c.cnt}; // R15 R17
      end
      return is_reg_write(c.op) ? buffer[4'(idx - ascd_pkg::N_HDR_BYTES)] : ascd_pkg::OP_NOP; // R16 R17
    end
    return c.op; // R1 R2 R5 R6 R18 R19 R20 R23 R24
  endfunction
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // both device outputs come from another clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_m <= 1'b0;
      dout_s <= 1'b0;
      rdy_m <= 1'b1;
      rdy_s <= 1'b1;
      rdy_d <= 1'b1;
    end else begin
      dout_m <= dout;
      dout_s <= dout_m;
      rdy_m <= data_ready_n;
      rdy_s <= rdy_m;
      rdy_d <= rdy_s;
    end
  end
  logic rdy_fall; // data ready just went low
  logic go_rise; // serial clock about to rise
  logic go_fall; // serial clock about to fall
  logic byte_done; // last bit of a byte sampled
  logic xfer_end; // transfer fully finished
  logic [7:0] rx_byte; // completed incoming byte
  logic apb_setup; // apb setup cycle
  logic apb_wr; // apb write access edge
  logic cmd_go; // accepted command write
  ascd_pkg::ascd_cmd_t new_cmd; // command word being written
  assign rdy_fall = rdy_d && !rdy_s;
  assign go_rise = state == ascd_pkg::ST_SHIFT && ph == ascd_pkg::SCLK_HALF - 5'h01 && !link_o.sclk;
  assign go_fall = state == ascd_pkg::ST_SHIFT && ph == ascd_pkg::SCLK_HALF - 5'h01 && link_o.sclk;
  assign byte_done = go_fall && bitn == 3'h7;
  assign xfer_end = state == ascd_pkg::ST_GAP && ph == ascd_pkg::SCLK_HALF - 5'h01;
  assign rx_byte = {rx[6:0], dout_s};
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign new_cmd = ascd_pkg::ascd_cmd_t'(pwdata[14:0]);
  // an error answered in setup blocks the write at the access edge
  assign cmd_go = apb_wr && !pslverr && paddr == ascd_pkg::ADDR_CMD;
  // ----------------------------------------------------------------
  // sequencer and link pins
  // ----------------------------------------------------------------
  // mode 1 framing: din changes on rise, device samples on fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ascd_pkg::ST_PWRUP;
      wait_cnt <= 32'h0000_0000;
      ph <= 5'h00;
      bitn <= 3'h0;
      bi <= 5'h00;
      total <= 5'h01;
      tx <= 8'hFF;
      link_o <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b1};
    end else begin
      unique case (state)
        ascd_pkg::ST_PWRUP: begin
          // device is internally held in reset, keep the link quiet
          if (wait_cnt == 32'(POWERUP_CYC - 1)) begin // R21
            state <= ascd_pkg::ST_IDLE;
            wait_cnt <= 32'h0000_0000;
          end else begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
          end
        end
        ascd_pkg::ST_IDLE: begin
          if (cmd_go) begin
            bi <= 5'h00;
            total <= bytes_total(new_cmd);
            ph <= 5'h00;
            // continuous command may only go out after a data-ready fall
            if (new_cmd.wait_rdy || (is_cont(new_cmd.op) && !new_cmd.res_only)) begin // R10 R11
              state <= ascd_pkg::ST_WAIT_RDY;
            end else begin
              state <= ascd_pkg::ST_CS_SETUP;
            end
          end
        end
        ascd_pkg::ST_WAIT_RDY: begin
          if (rdy_fall) begin // R10 R11
            state <= ascd_pkg::ST_CS_SETUP;
          end
        end
        ascd_pkg::ST_CS_SETUP: begin
          // select falls anew for every command, which keeps the
          // device's serial logic in step before a reset
          link_o.cs_n <= 1'b0; // R7 R24
          if (ph == ascd_pkg::SCLK_HALF - 5'h01) begin
            ph <= 5'h00;
            bitn <= 3'h0;
            tx <= tx_byte(cmd, 5'h00);
            state <= ascd_pkg::ST_SHIFT;
          end else begin
            ph <= ph + 5'h01;
          end
        end
        ascd_pkg::ST_SHIFT: begin
          if (go_rise) begin
            ph <= 5'h00;
            link_o.sclk <= 1'b1;
            link_o.din <= tx[7];
          end else if (go_fall) begin
            ph <= 5'h00;
            link_o.sclk <= 1'b0;
            tx <= {tx[6:0], 1'b1};
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              if (bi == total - 5'h01) begin
                state <= ascd_pkg::ST_CS_END;
              end else begin
                bi <= bi + 5'h01;
                tx <= tx_byte(cmd, bi + 5'h01);
              end
            end
          end else begin
            ph <= ph + 5'h01;
          end
        end
        ascd_pkg::ST_CS_END: begin
          if (ph == ascd_pkg::SCLK_HALF - 5'h01) begin
            ph <= 5'h00;
            link_o.cs_n <= 1'b1;
            link_o.din <= 1'b1;
            state <= ascd_pkg::ST_GAP;
          end else begin
            ph <= ph + 5'h01;
          end
        end
        ascd_pkg::ST_GAP: begin
          if (xfer_end) begin
            ph <= 5'h00;
            wait_cnt <= 32'h0000_0000;
            if (is_reset(cmd.op) && !cmd.res_only) begin
              state <= ascd_pkg::ST_HOLD; // R8
            end else begin
              state <= ascd_pkg::ST_IDLE;
            end
          end else begin
            ph <= ph + 5'h01;
          end
        end
        ascd_pkg::ST_HOLD: begin
          // registers and filter are still held after a reset command
          if (wait_cnt == 32'(RESET_HOLD_CYC - 1)) begin // R6 R8
            state <= ascd_pkg::ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // receive path, byte buffer and result
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx <= 8'h00;
      result <= 24'h00_0000;
      for (int i = 0; i < 16; i++) begin
        buffer[i] <= 8'h00;
      end
    end else begin
      if (go_fall) begin
        rx <= rx_byte;
      end
      if (byte_done) begin
        if (cmd.res_only || (is_read_once(cmd.op) && bi != 5'h00)) begin
          result <= {result[15:0], rx_byte}; // R9 R13
        end else if (is_reg_read(cmd.op) && bi >= ascd_pkg::N_HDR_BYTES) begin
          buffer[4'(bi - ascd_pkg::N_HDR_BYTES)] <= rx_byte; // R15
        end
      end else if (apb_wr && !pslverr && paddr[11:6] == ascd_pkg::BUF_PAGE) begin
        // software loads write data only while the link is idle
        buffer[paddr[5:2]] <= pwdata[7:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // apb slave: command, flags, config
  // ----------------------------------------------------------------
  logic mapped; // address hits a register
  logic busy; // a command is in flight or a hold runs
  assign busy = state != ascd_pkg::ST_IDLE;
  assign mapped = paddr == ascd_pkg::ADDR_CMD || paddr == ascd_pkg::ADDR_STATUS ||
                  paddr == ascd_pkg::ADDR_RESULT || paddr == ascd_pkg::ADDR_CONFIG ||
                  (paddr[11:6] == ascd_pkg::BUF_PAGE && paddr[1:0] == 2'h0);
  // answer is prepared in setup so the slave never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        // busy or restricted commands and buffer writes in flight are refused
        pslverr <= !mapped || (pwrite && paddr == ascd_pkg::ADDR_CMD &&
                   (busy || pwdata[7:0] == ascd_pkg::OP_RESTRICTED)) || // R21 R8 R23
                   (pwrite && paddr[11:6] == ascd_pkg::BUF_PAGE && busy);
        prdata <= 32'h0000_0000;
        if (paddr == ascd_pkg::ADDR_CMD) begin
          prdata <= {17'h0_0000, cmd};
        end else if (paddr == ascd_pkg::ADDR_STATUS) begin
          prdata[ascd_pkg::ST_BUSY] <= busy;
          prdata[ascd_pkg::ST_HOLDING] <= state == ascd_pkg::ST_PWRUP ||
                                          state == ascd_pkg::ST_HOLD;
          prdata[ascd_pkg::ST_RDY_LEVEL] <= rdy_s;
          prdata[ascd_pkg::ST_CONT_MODE] <= cont_mode;
          prdata[ascd_pkg::ST_ERR] <= flag_err;
          prdata[ascd_pkg::ST_DONE] <= flag_done;
        end else if (paddr == ascd_pkg::ADDR_RESULT) begin
          prdata <= {8'h00, result};
        end else if (paddr == ascd_pkg::ADDR_CONFIG) begin
          prdata[ascd_pkg::CFG_START] <= conv_start;
        end else if (paddr[11:6] == ascd_pkg::BUF_PAGE) begin
          prdata <= {24'h00_0000, buffer[paddr[5:2]]};
        end
      end
    end
  end
  // accepted command word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '{wait_rdy: 1'b0, chain: 1'b0, res_only: 1'b0, cnt: 4'h0, op: ascd_pkg::OP_NOP};
    end else if (cmd_go) begin
      cmd <= new_cmd;
    end
  end
  // sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_err <= 1'b0;
      flag_done <= 1'b0;
    end else begin
      if (apb_wr && pslverr && paddr == ascd_pkg::ADDR_CMD) begin
        flag_err <= 1'b1;
      end else if (apb_wr && paddr == ascd_pkg::ADDR_STATUS && pwdata[ascd_pkg::ST_ERR]) begin
        flag_err <= 1'b0;
      end
      if (xfer_end) begin
        flag_done <= 1'b1;
      end else if (apb_wr && paddr == ascd_pkg::ADDR_STATUS && pwdata[ascd_pkg::ST_DONE]) begin
        flag_done <= 1'b0;
      end
    end
  end
  // tracked read mode: the device starts in continuous mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_mode <= 1'b1; // R22
    end else if (xfer_end && !cmd.res_only) begin
      if (is_cont(cmd.op) || is_reset(cmd.op)) begin
        cont_mode <= 1'b1; // R22
      end else if (is_stop(cmd.op)) begin
        cont_mode <= 1'b0; // R12
      end
    end
  end
  // start pin level; sleep and wake commands do the same in software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start <= 1'b1;
    end else if (apb_wr && paddr == ascd_pkg::ADDR_CONFIG) begin
      conv_start <= pwdata[ascd_pkg::CFG_START]; // R3 R4
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_quiet_hold;
    @(posedge pclk) disable iff (!presetn)
    (state == ascd_pkg::ST_PWRUP || state == ascd_pkg::ST_HOLD) |-> link_o.cs_n && !link_o.sclk;
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("link active during hold"); // R21
  property p_reset_hold;
    @(posedge pclk) disable iff (!presetn)
    (xfer_end && is_reset(cmd.op) && !cmd.res_only) |=> state == ascd_pkg::ST_HOLD;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("no hold after reset"); // R8
  property p_wait_quiet;
    @(posedge pclk) disable iff (!presetn)
    state == ascd_pkg::ST_WAIT_RDY |-> link_o.cs_n;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("select low before ready"); // R10
  property p_nop_readout;
    @(posedge pclk) disable iff (!presetn)
    (go_rise && is_reg_read(cmd.op) && !cmd.res_only && bi >= ascd_pkg::N_HDR_BYTES) |=>
      link_o.din;
  endproperty
  a_nop_readout: assert property (p_nop_readout) else $error("non-nop in readout"); // R16
  property p_count_byte;
    @(posedge pclk) disable iff (!presetn)
    (go_rise && bi == 5'h01 && bitn < 3'h4 && !cmd.res_only &&
     (is_reg_read(cmd.op) || is_reg_write(cmd.op))) |=> !link_o.din;
  endproperty
  a_count_byte: assert property (p_count_byte) else $error("count byte top not zero"); // R15
  property p_sclk_high;
    @(posedge pclk) disable iff (!presetn)
    $rose(link_o.sclk) |-> link_o.sclk[*8] ##1 !link_o.cs_n;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("clock high too short"); // R24
  property p_cs_gap;
    @(posedge pclk) disable iff (!presetn)
    $rose(link_o.cs_n) |-> link_o.cs_n[*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short"); // R7
  property p_stop_mode;
    @(posedge pclk) disable iff (!presetn)
    (xfer_end && !cmd.res_only && is_stop(cmd.op)) |=> !cont_mode ##1 !cont_mode;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop not tracked"); // R12
  property p_start_pin;
    @(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == ascd_pkg::ADDR_CONFIG) |=> conv_start == $past(pwdata[0]);
  endproperty
  a_start_pin: assert property (p_start_pin) else $error("start pin not updated"); // R4
  property p_result_bytes;
    @(posedge pclk) disable iff (!presetn)
    (state == ascd_pkg::ST_CS_SETUP && cmd.res_only) |-> total == ascd_pkg::N_RESULT_BYTES;
  endproperty
  a_result_bytes: assert property (p_result_bytes) else $error("result length wrong"); // R9
  c_reg_read: cover property (@(posedge pclk) disable iff (!presetn)
    xfer_end && is_reg_read(cmd.op) && cmd.cnt == 4'hF);
  c_reg_write: cover property (@(posedge pclk) disable iff (!presetn)
    xfer_end && is_reg_write(cmd.op));
  c_read_once: cover property (@(posedge pclk) disable iff (!presetn)
    xfer_end && is_read_once(cmd.op) && cmd.chain);
  c_reset_hold: cover property (@(posedge pclk) disable iff (!presetn)
    state == ascd_pkg::ST_HOLD ##1 state == ascd_pkg::ST_IDLE);
endmodule

/* File: design/ascd_pkg.sv */
// constants, types and register map of the converter command host
package ascd_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5; // pclk period, 200 MHz
  localparam int DEV_PWRUP_CYCLES = 65536; // device power-up hold in its own clocks
  localparam int DEV_CLK_KHZ = 4096; // device nominal system clock
  localparam int PWRUP_NS = (DEV_PWRUP_CYCLES * 1000 / DEV_CLK_KHZ) * 1000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_NS = 600000; // 0.6 ms hold after the reset command
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SCLK_HALF = 5'h10; // pclk cycles per serial clock half
  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WAKE = 8'h00;
  localparam logic [7:0] OP_SLEEP = 8'h02;
  localparam logic [7:0] OP_SYNC = 8'h04;
  localparam logic [7:0] OP_RESET = 8'h06;
  localparam logic [7:0] OP_NOP = 8'hFF;
  localparam logic [7:0] OP_READ_ONCE = 8'h12;
  localparam logic [7:0] OP_CONT_READ = 8'h14;
  localparam logic [7:0] OP_STOP_CONT = 8'h16;
  localparam logic [3:0] OP_REG_READ_HI = 4'h2;
  localparam logic [3:0] OP_REG_WRITE_HI = 4'h4;
  localparam logic [7:0] OP_SYS_OFS_CAL = 8'h60;
  localparam logic [7:0] OP_SYS_GAIN_CAL = 8'h61;
  localparam logic [7:0] OP_SELF_OFS_CAL = 8'h62;
  localparam logic [7:0] OP_RESTRICTED = 8'hF1;
  localparam logic [4:0] N_HDR_BYTES = 5'h02; // opcode and count bytes
  localparam logic [4:0] N_RESULT_BYTES = 5'h03; // 24-bit result
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  localparam logic [11:0] ADDR_CONFIG = 12'h00C;
  localparam logic [5:0] BUF_PAGE = 6'h01; // paddr[11:6] of the byte buffer
  localparam int ST_BUSY = 0;
  localparam int ST_HOLDING = 1;
  localparam int ST_RDY_LEVEL = 2;
  localparam int ST_CONT_MODE = 3;
  localparam int ST_ERR = 4;
  localparam int ST_DONE = 5;
  localparam int CFG_START = 0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wait_rdy; // wait for a data-ready fall first
    logic chain; // append a read-once in the last result byte
    logic res_only; // clock out a result with no opcode
    logic [3:0] cnt; // register count minus one
    logic [7:0] op; // opcode byte
  } ascd_cmd_t;
  typedef struct packed {
    logic sclk; // serial clock
    logic cs_n; // chip select, active low
    logic din; // host to device data
  } ascd_link_t;
  typedef enum logic [2:0] {
    ST_PWRUP, ST_IDLE, ST_WAIT_RDY, ST_CS_SETUP, ST_SHIFT, ST_CS_END, ST_GAP, ST_HOLD
  } ascd_state_t;
endpackage

/* File: verif/ascd_dev_model.sv */
// behavioural converter model on the far side of the serial link
`timescale 1ns/1ps
module ascd_dev_model (
  input wire logic sclk, // serial clock from host
  input wire logic cs_n, // chip select, active low
  input wire logic din, // host to device data
  output logic dout, // device data out
  output logic data_ready_n // data ready, active low
);
  logic [7:0] regs [16]; // user registers
  logic [7:0] rx, ob, op, last_op; // shift in, shift out, opcode
  int nb, nbit; // byte and bit counters of the frame
  logic [23:0] res; // conversion result handed out
  logic pend, rd; // result waiting for a frame, frame opens as a readout
  // free-running data ready pulse, one result per period
  initial begin
    dout = 1'b0;
    op = 8'hFF;
    res = 24'hA5C33C;
    pend = 1'b0;
    rd = 1'b0;
    data_ready_n = 1'b1;
    forever begin
      #20000 data_ready_n = 1'b0;
      pend = 1'b1;
      #200 data_ready_n = 1'b1;
    end
  end
  // a new frame always starts with an opcode
  always @(negedge cs_n) begin
    nb = 0;
    nbit = 0;
    op = 8'hFF;
    rd = pend;
    pend = 1'b0;
  end
  // released line shows the inverse of its last value, not a held bit
  always @(posedge cs_n) dout <= ~dout;
  // shift out on rise: result bytes or register bytes, else ones
  always @(posedge sclk) if (!cs_n) begin
    if (nbit == 0) begin
      ob = 8'hFF;
      if (rd && nb < 3) ob = 8'(res >> (8 * (2 - nb)));
      if (op == 8'h12 && nb > 0 && nb < 4) ob = 8'(res >> (8 * (3 - nb)));
      if (op[7:4] == 4'h2 && nb > 1) ob = regs[4'(op[3:0] + nb - 2)];
    end
    dout <= ob[7];
    ob = ob << 1;
  end
  // sample on fall; the first byte is always the opcode, a read-once in byte 3 of a read-once sets pend
  always @(negedge sclk) if (!cs_n) begin
    rx = {rx[6:0], din};
    nbit++;
    if (nbit == 8) begin
      nbit = 0;
      if (nb == 0) begin
        op = rx;
        last_op = rx;
      end else if (op[7:4] == 4'h4 && nb > 1) regs[4'(op[3:0] + nb - 2)] = rx;
      // each finished result read sees a fresh conversion, so stale data shows
      if ((op == 8'h12 && nb == 3) || (rd && op == 8'hFF && nb == 2)) res = ~res;
      if (op == 8'h12 && nb == 3 && rx == 8'h12) pend = 1'b1;
      nb++;
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the converter command host
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_start, dout, data_ready_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, d, exp_q[$], msk_q[$];
  logic [7:0] ops [9];
  int n_errors, checks_done, seed, k;
  ascd_pkg::ascd_link_t lk;
  ascd_host #(.POWERUP_CYC(50), .RESET_HOLD_CYC(40)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_o(lk), .conv_start(conv_start),
    .dout(dout), .data_ready_n(data_ready_n));
  ascd_dev_model u_dev (.sclk(lk.sclk), .cs_n(lk.cs_n), .din(lk.din), .dout(dout),
    .data_ready_n(data_ready_n));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task complete_run;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer; an idle edge follows so strobes are never set twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      complete_run;
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // bounded poll until a status bit clears
  task wbit(input int b);
    int i;
    for (i = 0; i < 2000; i++) begin
      apb(1'b0, ascd_pkg::ADDR_STATUS, 32'h0);
      if (rv[b] === 1'b0) break;
    end
    if (i == 2000) begin
      n_errors++;
      complete_run;
    end
  endtask
  // watcher: each completed read while a note is queued is matched against the oldest note
  always @(posedge pclk) if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    chk(prdata & msk_q.pop_front(), exp_q.pop_front());
  initial begin
    seed = 32'h25b83f3b;
    n_errors = 0;
    checks_done = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ops = '{8'h00, 8'h02, 8'h04, 8'h16, 8'h60, 8'h61, 8'h62, 8'h06, 8'h14};
    repeat (4) @(posedge pclk);
    chk({pready, lk.cs_n, conv_start}, 32'h3);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'h0);
    chk(err, 32'h1);
    rc(ascd_pkg::ADDR_STATUS, 32'h2, 32'h2);
    wbit(ascd_pkg::ST_HOLDING);
    foreach (ops[j]) begin
      apb(1'b1, ascd_pkg::ADDR_CMD, {24'h0, ops[j]});
      wbit(ascd_pkg::ST_BUSY);
      chk(u_dev.last_op, ops[j]);
    end
    rc(ascd_pkg::ADDR_STATUS, 32'h8, 32'h8);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'hF1);
    chk(err, 32'h1);
    apb(1'b0, 12'hFF0, 32'h0);
    chk(err, 32'h1);
    rc(ascd_pkg::ADDR_STATUS, 32'h30, 32'h30);
    d = $random(seed);
    apb(1'b1, 12'h040, {24'h0, d[7:0]});
    apb(1'b1, 12'h044, {24'h0, d[15:8]});
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'h14F);
    wbit(ascd_pkg::ST_BUSY);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'hF2F);
    wbit(ascd_pkg::ST_BUSY);
    rc(12'h040, {24'h0, d[7:0]}, 32'hFF);
    rc(12'h044, {24'h0, d[15:8]}, 32'hFF);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'h2012);
    wbit(ascd_pkg::ST_BUSY);
    rc(ascd_pkg::ADDR_RESULT, 32'hA5C33C, 32'hFFFFFF);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'h10FF);
    wbit(ascd_pkg::ST_BUSY);
    rc(ascd_pkg::ADDR_RESULT, 32'h5A3CC3, 32'hFFFFFF);
    apb(1'b1, ascd_pkg::ADDR_CMD, 32'h50FF);
    wbit(ascd_pkg::ST_BUSY);
    rc(ascd_pkg::ADDR_RESULT, 32'hA5C33C, 32'hFFFFFF);
    apb(1'b1, ascd_pkg::ADDR_CONFIG, 32'h0);
    chk(conv_start, 32'h0);
    complete_run;
  end
endmodule
